// ===== inc/bwp_pkg.sv
// Package: register map, key patterns and timing for the write protection lock
package bwp_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_KEY = 4'h0;
    localparam logic [3:0] ADDR_GUARD = 4'h1;
    localparam logic [3:0] ADDR_FREE = 4'h2;
    localparam logic [7:0] KEY_RESET = 8'h07;
    localparam logic [7:0] GUARD_RESET = 8'h00;
    localparam logic [7:0] FREE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int KEY_LSB = 3;
    localparam int STATUS_BIT = 2;
    localparam int DIV_LSB = 0;
    localparam int DIV_WIDTH = 4;
    localparam int WDT_BIT = 4;
    localparam int PD_BIT = 5;
    localparam int SD_BIT = 6;

    // ------------------------------------------------------------
    // Key patterns and scheme settings
    // ------------------------------------------------------------
    localparam logic [4:0] KEY_MODE = 5'h18;
    localparam logic [4:0] KEY_OPEN = 5'h13;
    localparam logic [4:0] KEY_CLOSE = 5'h15;
    localparam logic [1:0] SCHEME_OFF = 2'h0;
    localparam logic [1:0] SCHEME_ON = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int OPEN_CYCLES = 32;
    localparam int CNT_WIDTH = 6;

    typedef enum logic [1:0] {
        BWP_CMD_NONE,
        BWP_CMD_MODE,
        BWP_CMD_OPEN,
        BWP_CMD_CLOSE
    } bwp_cmd_e;

    function automatic bwp_cmd_e bwp_decode(input logic [4:0] key);
        bwp_cmd_e cmd;
        cmd = BWP_CMD_NONE;
        case (key)
            KEY_MODE: cmd = BWP_CMD_MODE;
            KEY_OPEN: cmd = BWP_CMD_OPEN;
            KEY_CLOSE: cmd = BWP_CMD_CLOSE;
            default: cmd = BWP_CMD_NONE;
        endcase
        return cmd;
    endfunction : bwp_decode
endpackage : bwp_pkg

// ===== inc/bwp_lock_if.sv
// Interface: lock state between the key logic and the guarded register
interface bwp_lock_if;
    logic guard_open;
    logic key_cmd_valid;
    bwp_pkg::bwp_cmd_e key_cmd;
    logic [1:0] scheme_wdata;

    modport key_side (
        input key_cmd_valid,
        input key_cmd,
        input scheme_wdata,
        output guard_open
    );
    modport bus_side (
        output key_cmd_valid,
        output key_cmd,
        output scheme_wdata,
        input guard_open
    );
endinterface : bwp_lock_if

// ===== verilog/bwp_key_fsm.sv
// Key sequencer: scheme setting, open window and countdown
module bwp_key_fsm #(
    parameter int OPEN_CYCLES = bwp_pkg::OPEN_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    bwp_lock_if.key_side lk,
    output logic [1:0] scheme
);
    typedef enum logic [1:0] {BWP_CLOSED, BWP_OPEN} bwp_state_e;

    bwp_state_e state;
    bwp_state_e next_state;
    logic [bwp_pkg::CNT_WIDTH-1:0] count;
    logic [bwp_pkg::CNT_WIDTH-1:0] next_count;
    logic [1:0] next_scheme;

    localparam logic [bwp_pkg::CNT_WIDTH-1:0] FULL =
        bwp_pkg::CNT_WIDTH'(OPEN_CYCLES);

    wire cmd_open = lk.key_cmd_valid && lk.key_cmd == bwp_pkg::BWP_CMD_OPEN;
    wire cmd_close = lk.key_cmd_valid && lk.key_cmd == bwp_pkg::BWP_CMD_CLOSE;
    wire cmd_mode = lk.key_cmd_valid && lk.key_cmd == bwp_pkg::BWP_CMD_MODE;
    wire scheme_off = scheme == bwp_pkg::SCHEME_OFF;

    always_comb begin
        next_state = state;
        next_count = count;
        next_scheme = scheme;
        if (cmd_mode) begin
            next_scheme = lk.scheme_wdata; // [R8]
        end
        case (state)
            BWP_CLOSED: begin
                if (cmd_open && !scheme_off) begin
                    next_state = BWP_OPEN; // [R3]
                    next_count = FULL; // [R5]
                end
            end
            BWP_OPEN: begin
                if (cmd_close) begin
                    next_state = BWP_CLOSED; // [R4]
                    next_count = '0;
                end else if (cmd_open) begin
                    next_count = FULL; // [R6]
                end else if (count == 6'h01) begin
                    next_state = BWP_CLOSED; // [R5]
                    next_count = '0;
                end else begin
                    next_count = count - 6'h01;
                end
            end
            default: begin
                next_state = BWP_CLOSED;
                next_count = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= BWP_CLOSED; // [R11]
            count <= '0;
            scheme <= bwp_pkg::SCHEME_ON;
        end else begin
            state <= next_state;
            count <= next_count;
            scheme <= next_scheme;
        end
    end

    // Open while unlocked, or always when the scheme is disabled
    assign lk.guard_open = (state == BWP_OPEN) || scheme_off; // [R7] [R12]
endmodule : bwp_key_fsm

// ===== verilog/bwp_guard_reg.sv
// Guarded control bits that only change while access is open
module bwp_guard_reg (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    input wire logic guard_open,
    output logic [7:0] value
);
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            value <= bwp_pkg::GUARD_RESET;
        end else if (wr_en && guard_open) begin // [R1]
            value <= wdata;
        end
    end
endmodule : bwp_guard_reg

// ===== verilog/bwp_top.sv
// Top: bit write protection lock with its register port and guarded bits
// Functional notes
// [R1] Writes to guarded bits are ignored while protection on and access closed.
// [R2] Guarded: divider factor, watchdog enable, power-down, slow-down; rest free.
// [R3] With scheme 11, key 10011 opens access to all guarded bits.
// [R4] Key 10101 closes access immediately.
// [R5] Open access closes by itself after 32 core clock cycles.
// [R6] Writing the open key again restarts the full 32-cycle count.
// [R7] Scheme 00 is disabled; 11 and any other value mean enabled.
// [R8] Scheme field changes only together with key 11000.
// [R9] Key register bit 2 reads 0 when writable, 1 when blocked.
// [R10] Other key values change neither lock state nor scheme.
// [R11] Reset gives scheme 11 with access closed, key reading 07.
// [R12] With scheme 00, guarded writes need no key; status reads 0.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
module bwp_top #(
    parameter int OPEN_CYCLES = bwp_pkg::OPEN_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic [3:0] clock_divider_factor,
    output logic watchdog_enable_bit,
    output logic power_down_request,
    output logic slow_down_request,
    output logic [7:0] free_bits,
    output logic write_protect_status
);
    // ------------------------------------------------------------
    // Address decode and key command
    // ------------------------------------------------------------
    bwp_lock_if lk ();

    wire wr_key = wr && addr == bwp_pkg::ADDR_KEY;
    wire wr_guard = wr && addr == bwp_pkg::ADDR_GUARD;
    wire wr_free = wr && addr == bwp_pkg::ADDR_FREE;
    wire [4:0] key_field = wdata[7:bwp_pkg::KEY_LSB];
    wire bwp_pkg::bwp_cmd_e key_cmd = bwp_pkg::bwp_decode(key_field); // [R10]

    assign lk.key_cmd_valid = wr_key && key_cmd != bwp_pkg::BWP_CMD_NONE;
    assign lk.key_cmd = key_cmd;
    assign lk.scheme_wdata = wdata[1:0];

    // ------------------------------------------------------------
    // Lock sequencer and guarded register
    // ------------------------------------------------------------
    logic [1:0] scheme;
    logic [7:0] guard_value;
    logic [7:0] free_value;

    bwp_key_fsm #(
        .OPEN_CYCLES(OPEN_CYCLES)
    ) u_fsm (
        .mclk(mclk),
        .arst_n(arst_n),
        .lk(lk),
        .scheme(scheme)
    );

    // Only the guarded fields are stored; unused bits stay zero
    wire [7:0] guard_mask = {1'b0, 1'b1, 1'b1, 1'b1, 4'hf}; // [R2]

    bwp_guard_reg u_guard (
        .mclk(mclk),
        .arst_n(arst_n),
        .wr_en(wr_guard),
        .wdata(wdata & guard_mask),
        .guard_open(lk.guard_open),
        .value(guard_value)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            free_value <= bwp_pkg::FREE_RESET;
        end else if (wr_free) begin // [R2]
            free_value <= wdata;
        end
    end

    // ------------------------------------------------------------
    // Read path, key field reads back as zero
    // ------------------------------------------------------------
    wire status = ~lk.guard_open; // [R9]
    wire [7:0] key_read = {5'h00, status, scheme};
    wire [7:0] read_mux =
        (addr == bwp_pkg::ADDR_KEY) ? key_read :
        (addr == bwp_pkg::ADDR_GUARD) ? guard_value :
        (addr == bwp_pkg::ADDR_FREE) ? free_value :
        bwp_pkg::UNMAPPED_READ;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= read_mux;
        end else begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            clock_divider_factor <= 4'h0;
            watchdog_enable_bit <= 1'b0;
            power_down_request <= 1'b0;
            slow_down_request <= 1'b0;
            free_bits <= 8'h00;
            write_protect_status <= 1'b1; // [R11]
        end else begin
            clock_divider_factor <= next_div;
            watchdog_enable_bit <= next_wdt;
            power_down_request <= next_pd;
            slow_down_request <= next_sd;
            free_bits <= free_next;
            write_protect_status <= next_status;
        end
    end

    // Outputs follow the stored registers with one cycle of latency
    wire [3:0] next_div = guard_value[bwp_pkg::DIV_LSB +: bwp_pkg::DIV_WIDTH];
    wire next_wdt = guard_value[bwp_pkg::WDT_BIT];
    wire next_pd = guard_value[bwp_pkg::PD_BIT];
    wire next_sd = guard_value[bwp_pkg::SD_BIT];
    wire [7:0] free_next = free_value;
    wire next_status = status;
endmodule : bwp_top

// ===== sim/bwp_assertions.sv
// Checker: lock window, guarded writes and read-back of the lock
module bwp_assertions #(
    parameter int OPEN_CYCLES = bwp_pkg::OPEN_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [3:0] clock_divider_factor,
    input wire logic watchdog_enable_bit,
    input wire logic power_down_request,
    input wire logic slow_down_request,
    input wire logic [7:0] free_bits,
    input wire logic write_protect_status
);
    logic [1:0] scheme_m;
    logic [6:0] since_open;
    wire key_wr = wr && addr == bwp_pkg::ADDR_KEY;
    wire [4:0] key = wdata[7:3];
    wire [6:0] wd7 = wdata[6:0];
    wire [6:0] g = {slow_down_request, power_down_request,
        watchdog_enable_bit, clock_divider_factor};
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    // Scheme copy, and cycles since an accepted open key
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scheme_m <= bwp_pkg::SCHEME_ON;
            since_open <= 7'h00;
        end else if (key_wr) begin
            if (key == bwp_pkg::KEY_MODE)
                scheme_m <= wdata[1:0];
            since_open <= {6'h00, key == bwp_pkg::KEY_OPEN && scheme_m != 0};
        end else if (since_open != 7'h00 && since_open != 7'h7f) begin
            since_open <= since_open + 7'h01;
        end
    end
    key_readback_a: assert property (rd && addr == bwp_pkg::ADDR_KEY |=>
        rdata == {5'h00, write_protect_status, $past(scheme_m)})
        else $error("key read-back wrong");
    close_key_a: assert property (key_wr && key == bwp_pkg::KEY_CLOSE &&
        scheme_m != 0 ##1 !key_wr |=> write_protect_status)
        else $error("close key did not block");
    open_window_a: assert property (
        since_open inside {[2:OPEN_CYCLES + 1]} |-> !write_protect_status)
        else $error("access closed inside window");
    window_end_a: assert property (
        since_open == OPEN_CYCLES + 2 |-> write_protect_status)
        else $error("access not closed after window");
    guard_block_a: assert property (wr && addr == bwp_pkg::ADDR_GUARD
        ##1 write_protect_status |=> $stable(g))
        else $error("blocked guarded write took effect");
    guard_take_a: assert property (wr && addr == bwp_pkg::ADDR_GUARD
        ##1 !write_protect_status |=> g == $past(wd7, 2))
        else $error("open guarded write lost");
    free_write_a: assert property (wr && addr == bwp_pkg::ADDR_FREE
        |-> ##2 free_bits == $past(wdata, 2))
        else $error("free write lost");
    scheme_off_a: assert property (
        (scheme_m == bwp_pkg::SCHEME_OFF)[*3] |-> !write_protect_status)
        else $error("status set while scheme off");
endmodule : bwp_assertions

bind bwp_top bwp_assertions #(.OPEN_CYCLES(OPEN_CYCLES)) chk (.mclk, .arst_n,
    .addr, .wdata, .wr, .rd, .rdata, .clock_divider_factor,
    .watchdog_enable_bit, .power_down_request, .slow_down_request,
    .free_bits, .write_protect_status);

// ===== sim/testbench.sv
// Testbench: random and corner-case register traffic for the lock
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, free_bits, r, d;
    logic [3:0] div;
    logic wdt, pd, sd, status;
    logic [6:0] g_exp;
    logic [1:0] sch;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #20 mclk = ~mclk;
    bwp_top uut (.mclk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
        .clock_divider_factor(div), .watchdog_enable_bit(wdt),
        .power_down_request(pd), .slow_down_request(sd), .free_bits,
        .write_protect_status(status));
    function automatic logic [7:0] key_exp(logic [1:0] s, logic open);
        return {5'h00, s != bwp_pkg::SCHEME_OFF && !open, s};
    endfunction : key_exp
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic wreg(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        v = rdata;
    endtask : rreg
    task automatic key(input logic [4:0] p);
        wreg(bwp_pkg::ADDR_KEY, {p, 3'(d)});
    endtask : key
    // Guarded write; ok says whether the lock lets it through
    task automatic gw(input logic ok);
        d = 8'($urandom);
        wreg(bwp_pkg::ADDR_GUARD, d);
        if (ok)
            g_exp = d[6:0];
        repeat (2) @(negedge mclk);
        check({1'b0, sd, pd, wdt, div}, {1'b0, g_exp});
    endtask : gw
    task automatic key_chk(input logic open);
        rreg(bwp_pkg::ADDR_KEY, r);
        check(r, key_exp(sch, open));
    endtask : key_chk
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(16));
        sch = bwp_pkg::SCHEME_ON;
        g_exp = 7'h00;
        cyc(20);
        arst_n <= 1'b1;
        key_chk(1'b0);
        gw(1'b0);
        d = 8'($urandom);
        wreg(bwp_pkg::ADDR_FREE, d);
        repeat (2) @(negedge mclk);
        check(free_bits, d);
        key(bwp_pkg::KEY_OPEN);
        key_chk(1'b1);
        gw(1'b1);
        key(bwp_pkg::KEY_CLOSE);
        gw(1'b0);
        // Last accepted edge of the window, then one edge too late
        for (int i = 0; i < 2; i++) begin
            key(bwp_pkg::KEY_OPEN);
            cyc(30 + i);
            gw(i == 0);
        end
        key(bwp_pkg::KEY_OPEN);
        cyc(20);
        key(bwp_pkg::KEY_OPEN);
        cyc(30);
        gw(1'b1);
        key(bwp_pkg::KEY_CLOSE);
        repeat (8) begin
            d = 8'($urandom);
            if (d[7:3] inside {bwp_pkg::KEY_MODE, bwp_pkg::KEY_OPEN,
                bwp_pkg::KEY_CLOSE})
                d[7:3] = 5'h1f;
            wreg(bwp_pkg::ADDR_KEY, d);
            key_chk(1'b0);
        end
        for (int s = 0; s < 4; s++) begin
            d = {5'h00, 1'b0, 2'(s)};
            key(bwp_pkg::KEY_MODE);
            sch = 2'(s);
            key_chk(1'b0);
            gw(sch == bwp_pkg::SCHEME_OFF);
        end
        wreg(4'h9, 8'hff);
        rreg(4'h9, r);
        check(r, bwp_pkg::UNMAPPED_READ);
        arst_n <= 1'b0;
        cyc(2);
        arst_n <= 1'b1;
        g_exp = 7'h00;
        key_chk(1'b0);
        gw(1'b0);
        stop_test();
    end
endmodule : testbench
